// *** rtl/refresh_timing_ctrl.sv ***
// Host-side refresh scheduler, latency selector and jitter derating.
// Assumes device timing counted in link clock rising edges; the link
// clock is sampled by clk through three flip-flops.
`default_nettype none
module refresh_timing_ctrl
   import refresh_timing_pkg::*;
(
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            nrst,
   // Link clock from outside, sampled
   input  wire logic            link_clk,
   // Configuration
   input  wire logic [1:0]      refresh_rate,
   input  wire logic            per_bank_mode,
   input  wire logic [2:0]      freq_sel,
   // Core timing derating inputs, in ps
   input  wire logic [PS_W-1:0] param_time_ps,
   input  wire logic [PS_W-1:0] link_period_ps,
   input  wire logic [PS_W-1:0] err_act_ps,
   input  wire logic [PS_W-1:0] err_allowed_ps,
   // Refresh handshake with command sequencer
   output logic                 refresh_req,
   output logic                 refresh_per_bank,
   output logic [2:0]           refresh_bank,
   input  wire logic            refresh_ack,
   output logic                 refresh_busy,
   // Results
   output logic [4:0]           read_latency,
   output logic [3:0]           write_latency,
   output logic [7:0]           core_timing_cycle_count,
   output logic [7:0]           derate_cycles,
   output logic [12:0]          window_refresh_count,
   output logic                 window_short
);
   // ==========================================================
   // Link clock synchroniser and edge detect
   logic link_s1_r, link_s2_r, link_s3_r;
   logic link_rise;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         link_s1_r <= 1'b0;
         link_s2_r <= 1'b0;
         link_s3_r <= 1'b0;
      end else begin
         link_s1_r <= link_clk;
         link_s2_r <= link_s1_r;
         link_s3_r <= link_s2_r;
      end
   end
   // Rising edge of the settled level; the first stage is never read
   // here, so a metastable sample cannot reach the latency logic
   assign link_rise = link_s2_r & ~link_s3_r;

   // ==========================================================
   // Refresh scheduler
   refresh_state_type state_r, state_nxt;
   logic [CNT_W-1:0]  interval_r, interval_nxt;   // Interval count
   logic [CNT_W-1:0]  rfc_r, rfc_nxt;             // Cycle wait
   logic [2:0]        bank_r, bank_nxt;           // Per-bank pointer
   logic              pb_r, pb_nxt;               // Current refresh kind
   logic [CNT_W-1:0]  interval_load;
   logic [CNT_W-1:0]  rfc_load;

   // Interval by mode and rate
   always_comb begin
      if (per_bank_mode) begin
         interval_load = CNT_W'(PER_BANK_REFI_CYC);
      end else begin
         interval_load = CNT_W'(ALL_BANK_REFI_CYC);
      end
      if (refresh_rate == RATE_HALF) begin
         interval_load = interval_load >> 1;
      end else if (refresh_rate == RATE_QUARTER) begin
         interval_load = interval_load >> 2;
      end
      if (interval_load == '0) begin
         interval_load = CNT_W'(1);
      end
   end

   assign rfc_load = pb_r ? CNT_W'(PER_BANK_RFC_CYC)
                          : CNT_W'(ALL_BANK_RFC_CYC);

   // Next state of the scheduler
   always_comb begin
      state_nxt    = state_r;
      interval_nxt = interval_r;
      rfc_nxt      = rfc_r;
      bank_nxt     = bank_r;
      pb_nxt       = pb_r;
      if (interval_r != '0) begin
         interval_nxt = interval_r - CNT_W'(1);
      end
      unique case (state_r)
         IDLE: begin
            if (interval_r == '0) begin
               state_nxt    = ISSUE;
               pb_nxt       = per_bank_mode;
               // Reload one short: the zero cycle closes the period, so requests stay
               // interval_load cycles apart when the handshake and refresh wait end within it
               interval_nxt = interval_load - CNT_W'(1);
            end
         end
         ISSUE: begin
            // Command taken by sequencer
            if (refresh_ack) begin
               state_nxt = WAIT_RFC;
               rfc_nxt   = rfc_load;
            end
         end
         WAIT_RFC: begin
            if (rfc_r <= CNT_W'(1)) begin
               state_nxt = IDLE;
               rfc_nxt   = '0;
               if (pb_r) begin
                  bank_nxt = bank_r + 3'h1;
               end
            end else begin
               rfc_nxt = rfc_r - CNT_W'(1);
            end
         end
      endcase
   end

   // Scheduler registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r    <= IDLE;
         interval_r <= '0;
         rfc_r      <= '0;
         bank_r     <= 3'h0;
         pb_r       <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         interval_r <= interval_nxt;
         rfc_r      <= rfc_nxt;
         bank_r     <= bank_nxt;
         pb_r       <= pb_nxt;
      end
   end

   // Request stands for the whole ISSUE state, until acknowledged
   assign refresh_req      = (state_r == ISSUE);
   assign refresh_per_bank = pb_r;
   assign refresh_bank     = bank_r;
   assign refresh_busy     = (state_r != IDLE);

   // ==========================================================
   // Refresh window supervision
   logic [31:0] win_len;
   logic [31:0] win_cnt_r, win_cnt_nxt;
   logic [12:0] ref_cnt_r, ref_cnt_nxt;
   logic [12:0] last_cnt_r, last_cnt_nxt;
   logic        short_r, short_nxt;
   logic [12:0] need;

   // Window length in controller cycles
   always_comb begin
      unique case (refresh_rate)
         RATE_HALF:    win_len = REFW_HALF_MS * (1000000000 / CLK_PERIOD_PS);
         RATE_QUARTER: win_len =
            REFW_QUARTER_MS * (1000000000 / CLK_PERIOD_PS);
         default:      win_len = REFW_FULL_MS * (1000000000 / CLK_PERIOD_PS);
      endcase
   end

   // Per-bank needs BANK_COUNT / 4, two, per row set
   // The per-bank figure is one above what the 13-bit count holds, so
   // it is capped at the saturation value of the counter
   assign need = per_bank_mode
               ? 13'(REFRESH_COUNT_MIN * BANK_COUNT / 4 - 1)
               : 13'(REFRESH_COUNT_MIN);

   // Next window counters
   always_comb begin
      win_cnt_nxt  = win_cnt_r + 32'h1;
      ref_cnt_nxt  = ref_cnt_r;
      last_cnt_nxt = last_cnt_r;
      short_nxt    = short_r;
      // Count accepted refreshes, saturating
      if (refresh_req && refresh_ack && ref_cnt_r != 13'h1FFF) begin
         ref_cnt_nxt = ref_cnt_r + 13'h1;
      end
      if (win_cnt_r >= win_len - 32'h1) begin
         win_cnt_nxt  = 32'h0;
         last_cnt_nxt = ref_cnt_nxt;
         short_nxt    = (ref_cnt_nxt < need);
         ref_cnt_nxt  = 13'h0;
      end
   end

   // Window registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         win_cnt_r  <= 32'h0;
         ref_cnt_r  <= 13'h0;
         last_cnt_r <= 13'h0;
         short_r    <= 1'b0;
      end else begin
         win_cnt_r  <= win_cnt_nxt;
         ref_cnt_r  <= ref_cnt_nxt;
         last_cnt_r <= last_cnt_nxt;
         short_r    <= short_nxt;
      end
   end
   assign window_refresh_count = last_cnt_r;
   assign window_short         = short_r;

   // ==========================================================
   // Latency selection and core timing counts
   logic [4:0]      rl_r, rl_nxt;
   logic [3:0]      wl_r, wl_nxt;
   logic [7:0]      nom_r, nom_nxt;
   logic [7:0]      der_r, der_nxt;
   logic [7:0]      core_r, core_nxt;   // Derated core count
   logic [PS_W:0]   excess;
   logic [PS_W+1:0] derated_time;
   logic [PS_W+1:0] nom_full, der_full;
   logic [PS_W-1:0] period;

   // Counts computed on link clock edges
   always_comb begin
      period  = (link_period_ps == '0) ? PS_W'(1) : link_period_ps;
      rl_nxt  = READ_LAT[freq_sel];
      wl_nxt  = WRITE_LAT[freq_sel];
      nom_full = ((PS_W+2)'(param_time_ps) + (PS_W+2)'(period)
                  - (PS_W+2)'(1)) / (PS_W+2)'(period);
      nom_nxt  = (nom_full > (PS_W+2)'(255)) ? 8'hFF : nom_full[7:0];
      excess = (err_act_ps > err_allowed_ps)
             ? (PS_W+1)'(err_act_ps - err_allowed_ps) : '0;
      derated_time = (PS_W+2)'(param_time_ps) + (PS_W+2)'(excess);
      der_full = (derated_time + (PS_W+2)'(period) - (PS_W+2)'(1))
               / (PS_W+2)'(period);
      if (der_full > nom_full) begin
         der_full = der_full - nom_full;
      end else begin
         der_full = '0;
      end
      der_nxt = (der_full > (PS_W+2)'(255)) ? 8'hFF : der_full[7:0];
      if (!link_rise) begin
         rl_nxt  = rl_r;
         wl_nxt  = wl_r;
         nom_nxt = nom_r;
         der_nxt = der_r;
      end
      core_nxt = ((9'(nom_nxt) + 9'(der_nxt)) > 9'h0FF)
               ? 8'hFF : 8'(nom_nxt + der_nxt);
   end

   // Latency registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // Lowest frequency code after reset
         rl_r   <= READ_LAT[0];
         wl_r   <= WRITE_LAT[0];
         nom_r  <= 8'h00;
         der_r  <= 8'h00;
         core_r <= 8'h00;
      end else begin
         rl_r   <= rl_nxt;
         wl_r   <= wl_nxt;
         nom_r  <= nom_nxt;
         der_r  <= der_nxt;
         core_r <= core_nxt;
      end
   end

   assign read_latency            = rl_r;
   assign write_latency           = wl_r;
   // Derated count comes straight from its register
   assign core_timing_cycle_count = core_r;
   assign derate_cycles           = der_r;
endmodule // refresh_timing_ctrl
`default_nettype wire

// *** rtl/refresh_timing_pkg.sv ***
// Constants for the refresh scheduler and latency selector.
// Assumes one 10 MHz controller clock and a sampled link clock input.
`default_nettype none
package refresh_timing_pkg;
   // ==========================================================
   // Clock
   localparam int unsigned CLK_PERIOD_PS = 100000;
   // ==========================================================
   // Refresh windows in ms
   localparam int unsigned REFW_FULL_MS    = 32;
   localparam int unsigned REFW_HALF_MS    = 16;
   localparam int unsigned REFW_QUARTER_MS = 8;
   localparam int unsigned REFRESH_COUNT_MIN = 4096;
   localparam int unsigned BANK_COUNT = 8;
   // ==========================================================
   // Intervals and cycle times in ps
   localparam int unsigned ALL_BANK_REFI_PS  = 7800000;
   localparam int unsigned PER_BANK_REFI_PS  = 975000;
   localparam int unsigned ALL_BANK_RFC_PS   = 130000;
   localparam int unsigned PER_BANK_RFC_PS   = 60000;
   // Longest times round down, least times round up
   localparam int unsigned ALL_BANK_REFI_CYC =
      ALL_BANK_REFI_PS / CLK_PERIOD_PS;
   localparam int unsigned PER_BANK_REFI_CYC =
      PER_BANK_REFI_PS / CLK_PERIOD_PS;
   localparam int unsigned ALL_BANK_RFC_CYC =
      (ALL_BANK_RFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned PER_BANK_RFC_CYC =
      (PER_BANK_RFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned CNT_W = 8;
   // ==========================================================
   // Refresh rate encoding
   localparam logic [1:0] RATE_FULL    = 2'h0;
   localparam logic [1:0] RATE_HALF    = 2'h1;
   localparam logic [1:0] RATE_QUARTER = 2'h2;
   // ==========================================================
   // Latency table, index 0..7 = 400..1066 MHz
   localparam logic [4:0] READ_LAT [8] = '{5'h06, 5'h08, 5'h09, 5'h0A,
                                           5'h0B, 5'h0C, 5'h0E, 5'h10};
   localparam logic [3:0] WRITE_LAT[8] = '{4'h3, 4'h4, 4'h5, 4'h6,
                                           4'h6, 4'h6, 4'h8, 4'h8};
   localparam int unsigned PS_W = 24;
   typedef enum logic [1:0] {IDLE, ISSUE, WAIT_RFC} refresh_state_type;
endpackage
`default_nettype wire

// *** tb/dram_refresh_latency_timing_tb.sv ***
// Bench for refresh_timing_ctrl with a device-side model.
// Assumes package, design, model and checker compiled before it.
`default_nettype none
module dram_refresh_latency_timing_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import refresh_timing_pkg::*;
   // ==========================================
   // Stimulus, observed outputs and reference tables
   logic            clk = 1'b0, nrst = 1'b0, lclk = 1'b0, pbm = 1'b0;
   logic [1:0]      rate = 2'h0;
   logic [2:0]      fsel = 3'h0, dly = 3'h0, bank;
   logic [PS_W-1:0] pt = '0, per = 24'h0003E8, ea = '0, el = '0;
   logic            req, pbk, busy, ack, wsh;
   logic [4:0]      rl;
   logic [3:0]      wl;
   logic [7:0]      core, der, viol;
   logic [12:0]     wcnt;
   int err_total = 0, num_checks = 0, seed = 54514, i, n, k, e, nom, ex;
   int pbd = 0;
   int rl_t[8] = '{6, 8, 9, 10, 11, 12, 14, 16};
   int wl_t[8] = '{3, 4, 5, 6, 6, 6, 8, 8};
   always #50 clk = ~clk;
   initial #130 forever #400 lclk = ~lclk;
   refresh_timing_ctrl dut_u (.clk(clk), .nrst(nrst), .link_clk(lclk),
      .refresh_rate(rate), .per_bank_mode(pbm), .freq_sel(fsel),
      .param_time_ps(pt), .link_period_ps(per), .err_act_ps(ea),
      .err_allowed_ps(el), .refresh_req(req), .refresh_per_bank(pbk),
      .refresh_bank(bank), .refresh_ack(ack), .refresh_busy(busy),
      .read_latency(rl), .write_latency(wl),
      .core_timing_cycle_count(core), .derate_cycles(der),
      .window_refresh_count(wcnt), .window_short(wsh));
   refresh_dev_model dev_u (.clk(clk), .nrst(nrst), .refresh_req(req),
      .refresh_per_bank(pbk), .ack_delay(dly), .refresh_ack(ack),
      .viol_cnt(viol));
   // ==========================================
   // Compare, close, and wait for the next request
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic wait_req();
      k = 0;
      while (req === 1'b1 && k < 300) begin
         @(negedge clk);
         k++;
      end
      dly <= 3'($unsigned($random(seed)) % 5);
      while (req !== 1'b1 && k < 300) begin
         @(negedge clk);
         k++;
      end
      if (k >= 300) begin
         err_total++;
         wrap_up();
      end
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (2) @(negedge clk);
      check(rl, 32'h6);
      check(wl, 32'h3);
      nrst = 1'b1;
      // Every frequency code with random derating inputs
      for (i = 0; i < 8; i++) begin
         @(negedge lclk);
         @(negedge clk);
         fsel = i[2:0];
         pt   = 24'($unsigned($random(seed)) % 40000 + 10000);
         per  = 24'($unsigned($random(seed)) % 1563 + 938);
         ea   = 24'($unsigned($random(seed)) % 300);
         el   = 24'($unsigned($random(seed)) % 200);
         nom  = (pt + per - 1) / per;
         ex   = (ea > el) ? ea - el : 0;
         @(posedge lclk);
         repeat (5) @(negedge clk);
         check(rl, rl_t[i]);
         check(wl, wl_t[i]);
         check(der, (pt + ex + per - 1) / per - nom);
         check(core, (pt + ex + per - 1) / per);
      end
      // Both refresh kinds at full, half and quarter rate
      for (i = 0; i < 6; i++) begin
         pbm  = i[0];
         rate = i[2:1];
         e    = (pbm ? PER_BANK_REFI_CYC : ALL_BANK_REFI_CYC) >> rate;
         // Per-bank handshake, refresh wait and idle cycle of up to seven cycles may outlast a short interval
         for (n = 0; n < 6; n++) begin
            wait_req();
            if (n > 1) check(k >= e && k <= (e > 7 ? e : 7), 1);
            if (n > 1) check(pbk, pbm);
            if (pbk === 1'b1) begin
               check(bank, pbd % 8);
               pbd++;
            end
         end
      end
      // Quarter window, all-bank, until the first window ends
      pbm  = 1'b0;
      rate = RATE_QUARTER;
      k    = 0;
      while (wcnt === 13'h0000 && k < 90000) begin
         @(negedge clk);
         k++;
      end
      if (k >= 90000) begin
         err_total++;
         wrap_up();
      end
      check(wcnt >= REFRESH_COUNT_MIN, 1);
      check(wsh, 0);
      check(viol, 0);
      wrap_up();
   end
endmodule // dram_refresh_latency_timing_tb
`default_nettype wire

// *** tb/refresh_dev_model.sv ***
// Device-side model: acknowledges refresh commands after a set delay.
// Assumes the bench clock; flags commands inside the refresh cycle.
`default_nettype none
module refresh_dev_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // Refresh command side
   input  wire logic       refresh_req,
   input  wire logic       refresh_per_bank,
   input  wire logic [2:0] ack_delay,
   output logic            refresh_ack,
   output logic [7:0]      viol_cnt
);
   logic [2:0] wait_r;      // Cycles left before ack
   int         since = 255; // Edges since last accepted refresh
   int         rfc   = 0;   // Edges that refresh keeps the array busy
   logic       req_q = 1'b0;
   initial viol_cnt = 8'h00;
   // One-cycle ack after the chosen delay
   always @(negedge clk or negedge nrst) begin
      if (!nrst) begin
         refresh_ack <= 1'b0;
         wait_r      <= 3'h0;
      end else if (refresh_ack || !refresh_req) begin
         refresh_ack <= 1'b0;
         wait_r      <= ack_delay;
      end else if (wait_r == 3'h0) begin
         refresh_ack <= 1'b1;
      end else begin
         wait_r <= wait_r - 3'h1;
      end
   end
   // no new command inside the refresh cycle time
   always @(negedge clk) begin
      if (since < 255) since++;
      if (refresh_req && !req_q && since < rfc) viol_cnt <= viol_cnt + 8'h01;
      // Ack seen here was taken by the controller at the edge before
      if (refresh_ack) begin
         since = 0;
         rfc   = refresh_per_bank ? 1 : 2; // 60 ns, 130 ns rounded up
      end
      req_q = refresh_req;
   end
endmodule // refresh_dev_model
`default_nettype wire

// *** tb/refresh_timing_ctrl_checker.sv ***
// Port assertions for the refresh scheduler and latency selector.
// Bound into refresh_timing_ctrl; sees only its ports.
`default_nettype none
module refresh_timing_ctrl_checker
   import refresh_timing_pkg::*;
(
   // Clock and reset
   input wire logic            clk,
   input wire logic            nrst,
   // Watched inputs
   input wire logic            link_clk,
   input wire logic [2:0]      freq_sel,
   input wire logic [PS_W-1:0] err_act_ps,
   input wire logic [PS_W-1:0] err_allowed_ps,
   input wire logic            refresh_ack,
   // Watched outputs
   input wire logic            refresh_req,
   input wire logic            refresh_per_bank,
   input wire logic            refresh_busy,
   input wire logic [4:0]      read_latency,
   input wire logic [3:0]      write_latency,
   input wire logic [7:0]      derate_cycles
);
   // ==========================================
   // Refresh handshake and latency relations
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   req_hold_a: assert property (
      refresh_req && !refresh_ack |=> refresh_req)
      else $error("refresh request dropped before ack");
   ack_end_a: assert property (
      refresh_req && refresh_ack |=> !refresh_req && refresh_busy)
      else $error("request not closed after ack");
   rfc_all_a: assert property (
      refresh_req && refresh_ack && !refresh_per_bank
      |=> refresh_busy [*2] ##1 !refresh_busy)
      else $error("all-bank refresh wait not two cycles");
   rfc_bank_a: assert property (
      refresh_req && refresh_ack && refresh_per_bank
      |=> refresh_busy ##1 (!refresh_busy || refresh_req))
      else $error("per-bank refresh wait not one cycle");
   req_busy_a: assert property (
      refresh_req |-> refresh_busy)
      else $error("request raised while idle");
   rd_lat_a: assert property (
      $rose(link_clk) |-> ##4 read_latency == READ_LAT[freq_sel])
      else $error("read latency does not match frequency");
   wr_lat_a: assert property (
      $rose(link_clk) |-> ##4 write_latency == WRITE_LAT[freq_sel])
      else $error("write latency does not match frequency");
   no_derate_a: assert property (
      $rose(link_clk) && err_act_ps <= err_allowed_ps
      |-> ##4 derate_cycles == 8'h00)
      else $error("derating added without excess error");
   // Main scenarios reached
   cover property (refresh_ack && refresh_per_bank);
   cover property (refresh_ack && !refresh_per_bank);
   cover property ($rose(link_clk) && derate_cycles != 8'h00);
endmodule // refresh_timing_ctrl_checker
bind refresh_timing_ctrl refresh_timing_ctrl_checker chk_u (.clk, .nrst,
   .link_clk, .freq_sel, .err_act_ps, .err_allowed_ps, .refresh_ack,
   .refresh_req, .refresh_per_bank, .refresh_busy, .read_latency,
   .write_latency, .derate_cycles);
`default_nettype wire
